// ---- txq_defs.svh ----
// offsets, field positions and reset values of the tx enqueuer
// -----------------------------------------------------------------------------
// Functional notes
// - a packet whose first fragment lacks the start flag is rejected
// - fragments counted up to end flag; early end or repeated start rejects
// - a packet with more fragments than the channel's slots is rejected
// - accepted packets queue behind earlier ones in submission order
// - new chain is linked to the running list only once fully written
// - whole packets move while free slots cover the next packet
// - each fragment takes the write slot; slot wraps, in-use count rises
// - every descriptor gets ownership; start and end flags are copied
// - only the start fragment's descriptor carries the packet length
// - last fragment has null next pointer, others point to next slot
// - buffer pointer is base plus offset; length is valid byte count
// - in-flight entries match the occupied slots one to one
// - first new slot and whether any slot is in use are recorded before posting
// - with earlier entries, the slot before the new chain links to it
// - with no earlier entries, the head pointer of the channel is written
// - the head pointer written is the one of the serviced channel
// - start flag is bit 31, end flag is bit 30 of the flag word
// - up to eight channels, each a ring in shared descriptor memory whose base and size can be set while it is empty
// - after a chain end with slots still in use, software restarts
// -----------------------------------------------------------------------------
`ifndef TXQ_DEFS_SVH
`define TXQ_DEFS_SVH

// -----------------------------------------------------------------------------
// register offsets (haddr[7:0])
// -----------------------------------------------------------------------------
`define TXQ_OFF_FRAG_BUF 8'h00
`define TXQ_OFF_FRAG_OFF 8'h04
`define TXQ_OFF_FRAG_LEN 8'h08
`define TXQ_OFF_PKT_INFO 8'h0c
`define TXQ_OFF_FRAG_PUSH 8'h10
`define TXQ_OFF_CHAIN_ABORT 8'h14
`define TXQ_OFF_STATUS 8'h18
`define TXQ_OFF_ERROR 8'h1c
`define TXQ_OFF_RELEASE 8'h20
`define TXQ_OFF_RESTART 8'h24
`define TXQ_OFF_DESC_BASE 8'h28
`define TXQ_OFF_CH_SEL 8'h2c
`define TXQ_OFF_CH_CFG 8'h30
`define TXQ_OFF_CH_STAT 8'h34

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define TXQ_FLAG_FIRST 31
`define TXQ_FLAG_LAST 30
`define TXQ_FLAG_OWNER 29
`define TXQ_ERR_BAD 0
`define TXQ_ERR_INVALID 1
`define TXQ_ERR_OVERFLOW 2
`define TXQ_WORD_NEXT 2'h0
`define TXQ_WORD_BUF 2'h1
`define TXQ_WORD_LEN 2'h2
`define TXQ_WORD_FLAGS 2'h3

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define TXQ_RST_SLOTS 9'h020
`define TXQ_RST_DESC_BASE 32'h0000_0000

`endif

// ---- txq_pkg.sv ----
// types shared by the tx enqueuer files
`default_nettype none
package txq_pkg;
  typedef struct packed {
    logic [31:0] ptr;
    logic [15:0] vlen;
    logic first;
    logic last;
  } txq_frag_t;

  typedef struct packed {
    logic [8:0] nfrag;
    logic [2:0] chan;
    logic [15:0] plen;
  } txq_pkt_t;

  typedef struct packed {
    logic en;
    logic [31:0] addr;
    logic [31:0] data;
  } txq_desc_wr_t;

  typedef struct packed {
    logic en;
    logic [2:0] chan;
    logic [31:0] ptr;
  } txq_head_wr_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_HDR, ST_CHECK, ST_FETCH, ST_WRITE, ST_LINK
  } txq_state_t;
endpackage
`default_nettype wire

// ---- txq_mem.sv ----
// simple dual-port memory with registered read data
`default_nettype none
module txq_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  // clock
  input wire logic hclk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
    $error("txq_mem: depth must be a power of two");
  end

  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge hclk) begin
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// ---- txq_enqueue.sv ----
// transmit descriptor enqueuer: ahb-lite command side, descriptor writer
`include "txq_defs.svh"
`default_nettype none
module txq_enqueue #(
  parameter int N_CH = 8,
  parameter int FRAG_DEPTH = 64,
  parameter int PKT_DEPTH = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // device side: descriptor memory and head pointer writes
  output txq_pkg::txq_desc_wr_t desc_wr,
  output txq_pkg::txq_head_wr_t head_wr
);
  localparam int FAW = $clog2(FRAG_DEPTH);
  localparam int PAW = $clog2(PKT_DEPTH);

  // queue pointers wrap by bit count, so depths must be powers of two
  if (N_CH < 1 || N_CH > 8 || FRAG_DEPTH < 2 || PKT_DEPTH < 2 ||
      (1 << FAW) != FRAG_DEPTH || (1 << PAW) != PKT_DEPTH) begin : g_bad
    $error("txq_enqueue: unsupported parameters");
  end

  // ---------------------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------------------
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] frag_buf_q, desc_base_q;
  logic [15:0] frag_off_q, frag_len_q, pkt_len_q;
  logic [2:0] pkt_chan_q, ch_sel_q;
  logic [2:0] err_q;
  logic push_w, abort_w, rel_w, rst_w, cfg_w;

  assign push_w = wr_pend_q && wr_addr_q == `TXQ_OFF_FRAG_PUSH;
  assign abort_w = wr_pend_q && wr_addr_q == `TXQ_OFF_CHAIN_ABORT;
  assign rel_w = wr_pend_q && wr_addr_q == `TXQ_OFF_RELEASE;
  assign rst_w = wr_pend_q && wr_addr_q == `TXQ_OFF_RESTART;
  assign cfg_w = wr_pend_q && wr_addr_q == `TXQ_OFF_CH_CFG;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= hsel && htrans[1] && hready && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frag_buf_q <= 32'h0000_0000;
      frag_off_q <= 16'h0000;
      frag_len_q <= 16'h0000;
      pkt_len_q <= 16'h0000;
      pkt_chan_q <= 3'h0;
      ch_sel_q <= 3'h0;
      desc_base_q <= `TXQ_RST_DESC_BASE;
    end else if (wr_pend_q) begin
      unique case (wr_addr_q)
        `TXQ_OFF_FRAG_BUF: frag_buf_q <= hwdata;
        `TXQ_OFF_FRAG_OFF: frag_off_q <= hwdata[15:0];
        `TXQ_OFF_FRAG_LEN: frag_len_q <= hwdata[15:0];
        `TXQ_OFF_PKT_INFO: begin
          pkt_chan_q <= hwdata[2:0];
          pkt_len_q <= hwdata[31:16];
        end
        `TXQ_OFF_DESC_BASE: desc_base_q <= hwdata;
        `TXQ_OFF_CH_SEL: ch_sel_q <= hwdata[2:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // per-channel rings
  // ---------------------------------------------------------------------------
  logic [7:0] base_q [8];
  logic [8:0] limit_q [8];
  logic [7:0] wr_slot_q [8];
  logic [7:0] rd_slot_q [8];
  logic [8:0] in_use_q [8];
  txq_pkg::txq_state_t st_q;
  logic [2:0] ch_q;
  logic adv;

  // a release larger than the count in use is ignored
  logic rel_ok;
  assign rel_ok = rel_w && {1'b0, hwdata[15:8]} <= in_use_q[hwdata[2:0]];

  function automatic logic [7:0] slot_after(input logic [7:0] s,
      input logic [7:0] b, input logic [8:0] l);
    logic [9:0] off;
    off = {2'b00, s} - {2'b00, b} + 10'h001;
    if (off >= {1'b0, l}) begin
      off = off - {1'b0, l};
    end
    slot_after = 8'(off + {2'b00, b});
  endfunction

  function automatic logic [7:0] slot_before(input logic [7:0] s,
      input logic [7:0] b, input logic [8:0] l);
    if (s == b) begin
      slot_before = 8'({1'b0, b} + l - 9'h001);
    end else begin
      slot_before = s - 8'h01;
    end
  endfunction

  for (genvar c = 0; c < 8; c++) begin : g_ch
    logic [9:0] roff;
    always_comb begin
      roff = {2'b00, rd_slot_q[c]} - {2'b00, base_q[c]} + {2'b00, hwdata[15:8]};
      if (roff >= {1'b0, limit_q[c]}) begin
        roff = roff - {1'b0, limit_q[c]};
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        base_q[c] <= 8'(c * `TXQ_RST_SLOTS);
        limit_q[c] <= `TXQ_RST_SLOTS;
      end else if (cfg_w && ch_sel_q == 3'(c) && in_use_q[c] == 9'h000) begin
        base_q[c] <= hwdata[7:0];
        limit_q[c] <= hwdata[16:8];
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        wr_slot_q[c] <= 8'(c * `TXQ_RST_SLOTS);
        rd_slot_q[c] <= 8'(c * `TXQ_RST_SLOTS);
        in_use_q[c] <= 9'h000;
      end else if (cfg_w && ch_sel_q == 3'(c) && in_use_q[c] == 9'h000) begin
        wr_slot_q[c] <= hwdata[7:0];
        rd_slot_q[c] <= hwdata[7:0];
      end else begin
        if (adv && ch_q == 3'(c)) begin
          wr_slot_q[c] <= slot_after(wr_slot_q[c], base_q[c], limit_q[c]);
        end
        if (rel_ok && hwdata[2:0] == 3'(c)) begin
          rd_slot_q[c] <= 8'(roff + {2'b00, base_q[c]});
        end
        in_use_q[c] <= in_use_q[c] + {8'h00, adv && ch_q == 3'(c)}
          - ((rel_ok && hwdata[2:0] == 3'(c)) ? {1'b0, hwdata[15:8]} : 9'h000);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // pending queues and packet validation
  // ---------------------------------------------------------------------------
  logic [FAW:0] f_tent_q, f_commit_q, f_rd_q;
  logic [PAW:0] p_wr_q, p_rd_q;
  logic build_q;
  logic [8:0] nfrag_q;
  logic [2:0] bchan_q;
  logic [15:0] blen_q;
  logic first_f, last_f, f_full, p_full, f_we, p_we, pop_frag, pop_pkt;
  logic [2:0] err_set;
  logic [8:0] cnt_new;
  txq_pkg::txq_frag_t f_wdata, f_rdata;
  txq_pkg::txq_pkt_t p_wdata, p_rdata;

  assign first_f = hwdata[`TXQ_FLAG_FIRST];
  assign last_f = hwdata[`TXQ_FLAG_LAST];
  assign f_full = (f_tent_q - f_rd_q) == (FAW + 1)'(FRAG_DEPTH);
  assign p_full = (p_wr_q - p_rd_q) == (PAW + 1)'(PKT_DEPTH);
  assign cnt_new = build_q ? nfrag_q + 9'h001 : 9'h001;
  assign f_wdata = '{ptr: frag_buf_q + {16'h0000, frag_off_q},
                     vlen: frag_len_q, first: first_f, last: last_f};
  assign p_wdata = '{nfrag: cnt_new, chan: build_q ? bchan_q : pkt_chan_q,
                     plen: build_q ? blen_q : pkt_len_q};

  always_comb begin
    err_set = 3'h0;
    f_we = 1'b0;
    p_we = 1'b0;
    if (push_w) begin
      if (!build_q && !first_f) begin
        err_set[`TXQ_ERR_BAD] = 1'b1;
      end else if (build_q && first_f) begin
        err_set[`TXQ_ERR_INVALID] = 1'b1;
      end else if (f_full || (last_f && p_full)) begin
        err_set[`TXQ_ERR_OVERFLOW] = 1'b1;
      end else if (last_f &&
          cnt_new > limit_q[build_q ? bchan_q : pkt_chan_q]) begin
        err_set[`TXQ_ERR_BAD] = 1'b1;
      end else begin
        f_we = 1'b1;
        p_we = last_f;
      end
    end else if (abort_w && build_q) begin
      err_set[`TXQ_ERR_INVALID] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      f_tent_q <= '0;
      f_commit_q <= '0;
      p_wr_q <= '0;
      build_q <= 1'b0;
      nfrag_q <= 9'h000;
      bchan_q <= 3'h0;
      blen_q <= 16'h0000;
    end else if (err_set != 3'h0) begin
      f_tent_q <= f_commit_q;
      build_q <= 1'b0;
    end else if (f_we) begin
      f_tent_q <= f_tent_q + 1'b1;
      nfrag_q <= cnt_new;
      build_q <= !last_f;
      if (!build_q) begin
        bchan_q <= pkt_chan_q;
        blen_q <= pkt_len_q;
      end
      if (last_f) begin
        f_commit_q <= f_tent_q + 1'b1;
        p_wr_q <= p_wr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_q <= 3'h0;
    end else begin
      err_q <= (err_q & ~((wr_pend_q && wr_addr_q == `TXQ_OFF_ERROR) ?
                hwdata[2:0] : 3'h0)) | err_set;
    end
  end

  txq_mem #(.WIDTH($bits(txq_pkg::txq_frag_t)), .DEPTH(FRAG_DEPTH)) u_frag (
    .hclk(hclk), .we(f_we), .waddr(f_tent_q[FAW-1:0]), .wdata(f_wdata),
    .raddr(f_rd_q[FAW-1:0]), .rdata(f_rdata)
  );

  txq_mem #(.WIDTH($bits(txq_pkg::txq_pkt_t)), .DEPTH(PKT_DEPTH)) u_pkt (
    .hclk(hclk), .we(p_we), .waddr(p_wr_q[PAW-1:0]), .wdata(p_wdata),
    .raddr(p_rd_q[PAW-1:0]), .rdata(p_rdata)
  );

  // ---------------------------------------------------------------------------
  // descriptor engine
  // ---------------------------------------------------------------------------
  logic [8:0] left_q;
  logic [1:0] wcnt_q;
  logic [7:0] org_slot_q;
  logic org_run_q;
  logic [15:0] plen_q;
  logic fits;
  logic [7:0] cur_slot, nxt_slot;
  logic [31:0] cur_addr, nxt_addr, org_addr;

  assign cur_slot = wr_slot_q[ch_q];
  assign nxt_slot = slot_after(cur_slot, base_q[ch_q], limit_q[ch_q]);
  assign cur_addr = desc_base_q + {20'h00000, cur_slot, 4'h0};
  assign nxt_addr = desc_base_q + {20'h00000, nxt_slot, 4'h0};
  assign org_addr = desc_base_q + {20'h00000, org_slot_q, 4'h0};
  // room for the whole next packet
  assign fits = ({1'b0, p_rdata.nfrag} + {1'b0, in_use_q[p_rdata.chan]})
                <= {1'b0, limit_q[p_rdata.chan]};
  assign adv = st_q == txq_pkg::ST_WRITE && wcnt_q == 2'h3;
  assign pop_frag = adv;
  assign pop_pkt = st_q == txq_pkg::ST_LINK;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= txq_pkg::ST_IDLE;
      ch_q <= 3'h0;
      left_q <= 9'h000;
      wcnt_q <= 2'h0;
      org_slot_q <= 8'h00;
      org_run_q <= 1'b0;
      plen_q <= 16'h0000;
      f_rd_q <= '0;
      p_rd_q <= '0;
    end else begin
      if (pop_frag) begin
        f_rd_q <= f_rd_q + 1'b1;
      end
      if (pop_pkt) begin
        p_rd_q <= p_rd_q + 1'b1;
      end
      unique case (st_q)
        txq_pkg::ST_IDLE: if (p_wr_q != p_rd_q) begin
          st_q <= txq_pkg::ST_HDR;
        end
        txq_pkg::ST_HDR: st_q <= txq_pkg::ST_CHECK;
        txq_pkg::ST_CHECK: begin
          if (fits) begin
            // record first new slot and count
            ch_q <= p_rdata.chan;
            org_slot_q <= wr_slot_q[p_rdata.chan];
            org_run_q <= in_use_q[p_rdata.chan] != 9'h000;
            left_q <= p_rdata.nfrag;
            plen_q <= p_rdata.plen;
            st_q <= txq_pkg::ST_FETCH;
          end else begin
            st_q <= txq_pkg::ST_IDLE;
          end
        end
        txq_pkg::ST_FETCH: begin
          wcnt_q <= 2'h0;
          st_q <= txq_pkg::ST_WRITE;
        end
        txq_pkg::ST_WRITE: begin
          wcnt_q <= wcnt_q + 2'h1;
          if (wcnt_q == 2'h3) begin
            left_q <= left_q - 9'h001;
            // link only after the last fragment
            st_q <= (left_q == 9'h001) ? txq_pkg::ST_LINK
                                       : txq_pkg::ST_FETCH;
          end
        end
        txq_pkg::ST_LINK: st_q <= txq_pkg::ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // device writes and restart
  // ---------------------------------------------------------------------------
  logic rs_pend_q;
  logic [2:0] rs_ch_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rs_pend_q <= 1'b0;
      rs_ch_q <= 3'h0;
    end else if (rst_w) begin
      rs_pend_q <= 1'b1;
      rs_ch_q <= hwdata[2:0];
    end else if (st_q != txq_pkg::ST_LINK && st_q != txq_pkg::ST_WRITE) begin
      // a restart waits while the engine owns the device write port
      rs_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      desc_wr <= '0;
      head_wr <= '0;
    end else begin
      desc_wr <= '0;
      head_wr <= '0;
      if (st_q == txq_pkg::ST_WRITE) begin
        desc_wr.en <= 1'b1;
        desc_wr.addr <= cur_addr + {28'h0000000, wcnt_q, 2'b00};
        unique case (wcnt_q)
          // null next on the last fragment
          `TXQ_WORD_NEXT: desc_wr.data <= (left_q == 9'h001) ? 32'h0 : nxt_addr;
          `TXQ_WORD_BUF: desc_wr.data <= f_rdata.ptr;
          `TXQ_WORD_LEN: desc_wr.data <= {16'h0000, f_rdata.vlen};
          // owner, start, end flags; length on start only
          `TXQ_WORD_FLAGS: desc_wr.data <= (32'h1 << `TXQ_FLAG_OWNER)
            | ({31'h0, f_rdata.first} << `TXQ_FLAG_FIRST)
            | ({31'h0, f_rdata.last} << `TXQ_FLAG_LAST)
            | (f_rdata.first ? {16'h0000, plen_q} : 32'h0);
        endcase
      end else if (st_q == txq_pkg::ST_LINK && org_run_q) begin
        // chain from the slot before the new chain
        desc_wr.en <= 1'b1;
        desc_wr.addr <= desc_base_q + {20'h00000,
          slot_before(org_slot_q, base_q[ch_q], limit_q[ch_q]), 4'h0};
        desc_wr.data <= org_addr;
      end else if (st_q == txq_pkg::ST_LINK) begin
        head_wr <= '{en: 1'b1, chan: ch_q, ptr: org_addr};
      end else if (rs_pend_q && in_use_q[rs_ch_q] != 9'h000) begin
        head_wr <= '{en: 1'b1, chan: rs_ch_q,
          ptr: desc_base_q + {20'h00000, rd_slot_q[rs_ch_q], 4'h0}};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && htrans[1] && hready && !hwrite) begin
      unique case (haddr[7:0])
        `TXQ_OFF_FRAG_BUF: hrdata <= frag_buf_q;
        `TXQ_OFF_FRAG_OFF: hrdata <= {16'h0000, frag_off_q};
        `TXQ_OFF_FRAG_LEN: hrdata <= {16'h0000, frag_len_q};
        `TXQ_OFF_PKT_INFO: hrdata <= {pkt_len_q, 13'h0000, pkt_chan_q};
        `TXQ_OFF_STATUS: hrdata <= {16'(f_tent_q - f_rd_q),
          8'(p_wr_q - p_rd_q), 6'h00, build_q, st_q != txq_pkg::ST_IDLE};
        `TXQ_OFF_ERROR: hrdata <= {29'h0, err_q};
        `TXQ_OFF_DESC_BASE: hrdata <= desc_base_q;
        `TXQ_OFF_CH_SEL: hrdata <= {29'h0, ch_sel_q};
        `TXQ_OFF_CH_CFG: hrdata <= {15'h0, limit_q[ch_sel_q], base_q[ch_sel_q]};
        `TXQ_OFF_CH_STAT: hrdata <= {rd_slot_q[ch_sel_q], wr_slot_q[ch_sel_q],
          7'h00, in_use_q[ch_sel_q]};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- txq_props.sv ----
// concurrent checks on the tx enqueuer ports
`default_nettype none
module txq_props (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus response
  input wire logic hreadyout,
  input wire logic hresp,
  // device side
  input wire txq_pkg::txq_desc_wr_t desc_wr,
  input wire txq_pkg::txq_head_wr_t head_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic fl_w;
  logic nx_w;
  assign fl_w = desc_wr.en && desc_wr.addr[3:0] == 4'hc;
  assign nx_w = desc_wr.en && desc_wr.addr[3:0] == 4'h0;
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_last;
    fl_w && desc_wr.data[30];
  endsequence
  sequence s_link;
    head_wr.en || nx_w;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_bus_okay: assert property (
    $past(hresetn) |-> hreadyout == 1'b1 && hresp == 1'b0)
    else $error("bus not ready or not okay");
  chk_word_order: assert property (
    fl_w |-> $past(nx_w, 3) && $past(desc_wr.en, 2) && $past(desc_wr.en)
      && $past(desc_wr.addr, 3) == desc_wr.addr - 32'hc)
    else $error("descriptor words out of order");
  chk_owner_set: assert property (
    fl_w |-> desc_wr.data[29] && desc_wr.data[28:16] == 13'h0)
    else $error("flags word lacks owner bit");
  chk_len_first: assert property (
    fl_w && !desc_wr.data[31] |-> desc_wr.data[15:0] == 16'h0)
    else $error("length on a later fragment");
  chk_last_null: assert property (
    s_last |-> $past(desc_wr.data, 3) == 32'h0)
    else $error("last fragment next pointer not null");
  chk_next_chain: assert property (
    fl_w && !desc_wr.data[30] |-> $past(desc_wr.data, 3) != 32'h0
      && $past(desc_wr.data[3:0], 3) == 4'h0)
    else $error("inner fragment next pointer bad");
  chk_link_after: assert property (
    s_last |-> ##[1:3] s_link)
    else $error("packet not linked after last fragment");
  chk_head_slot: assert property (
    head_wr.en |-> head_wr.ptr[3:0] == 4'h0)
    else $error("head pointer not on a slot");
endmodule

bind txq_enqueue txq_props i_props (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .desc_wr(desc_wr),
  .head_wr(head_wr));
`default_nettype wire

// ---- txq_dev_model.sv ----
// behavioural device: descriptor memory and per-channel head pointers
`default_nettype none
module txq_dev_model (
  // clock
  input wire logic hclk,
  // controller side
  input wire txq_pkg::txq_desc_wr_t desc_wr,
  input wire txq_pkg::txq_head_wr_t head_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] head [8];
  int frames = 0;
  function automatic int walk(input logic [31:0] p);
    int n;
    n = 0;
    for (int i = 0; i < 256 && p != 32'h0 && mem.exists(p); i++) begin
      if (mem[p + 32'hc][30])
        n++;
      if (mem[p] == 32'h0)
        mem[p + 32'hc][28] = 1'b1;
      p = mem[p];
    end
    return n;
  endfunction
  always @(posedge hclk)
    if (desc_wr.en)
      mem[desc_wr.addr] = desc_wr.data;
  always @(posedge hclk)
    if (head_wr.en) begin
      head[head_wr.chan] = head_wr.ptr;
      frames += walk(head_wr.ptr);
    end
endmodule
`default_nettype wire

// ---- tb_txq_enqueue.sv ----
// self-checking bench for the tx descriptor enqueuer
`include "txq_defs.svh"
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_txq_enqueue;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, base, rd;
  logic [1:0] htrans;
  txq_pkg::txq_desc_wr_t desc_wr;
  txq_pkg::txq_head_wr_t head_wr;
  logic [63:0] dq [$];
  logic [34:0] hq [$];
  int failures, num_checks;
  assign hready = hreadyout;
  txq_enqueue i_txq_enqueue (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .desc_wr(desc_wr), .head_wr(head_wr));
  txq_dev_model i_txq_dev_model (.hclk(hclk), .desc_wr(desc_wr),
    .head_wr(head_wr));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] sa(input int s);
    return base + 32'(s * 16);
  endfunction
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic pkt(input logic [2:0] ch, input int n, input int s,
                     input int rb, input int lim);
    logic [15:0] pl;
    logic [31:0] b, o, l, nx;
    int ns;
    pl = 16'($urandom);
    ahb(1'b1, `TXQ_OFF_PKT_INFO, {pl, 13'h0, ch});
    for (int i = 0; i < n; i++) begin
      b = $urandom;
      o = {16'h0, 16'($urandom)};
      l = {16'h0, 16'($urandom)};
      ns = rb + (s - rb + 1) % lim;
      nx = (i == n - 1) ? 32'h0 : sa(ns);
      dq.push_back({sa(s), nx});
      dq.push_back({sa(s) + 32'h4, b + o});
      dq.push_back({sa(s) + 32'h8, l});
      dq.push_back({sa(s) + 32'hc, i == 0, i == n - 1, 1'b1, 13'h0,
                    i == 0 ? pl : 16'h0});
      ahb(1'b1, `TXQ_OFF_FRAG_BUF, b);
      ahb(1'b1, `TXQ_OFF_FRAG_OFF, o);
      ahb(1'b1, `TXQ_OFF_FRAG_LEN, l);
      ahb(1'b1, `TXQ_OFF_FRAG_PUSH, {i == 0, i == n - 1, 30'h0});
      s = ns;
    end
  endtask
  task automatic drain();
    for (int i = 0; i < 500 && dq.size() + hq.size() > 0; i++)
      @(posedge hclk);
    `CHK(dq.size() + hq.size(), 0)
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog, output monitor
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    #200us;
    failures++;
    finish_test();
  end
  always @(posedge hclk) begin
    logic [63:0] e;
    logic [34:0] h;
    if (hresetn && desc_wr.en) begin
      e = dq.size() ? dq.pop_front() : 64'hx;
      `CHK({desc_wr.addr, desc_wr.data}, e)
    end
    if (hresetn && head_wr.en) begin
      h = hq.size() ? hq.pop_front() : 35'hx;
      `CHK({head_wr.chan, head_wr.ptr}, h)
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    failures = 0;
    num_checks = 0;
    rd = $urandom(32'h24039869);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk_rd(`TXQ_OFF_CH_STAT, 32'h0);
    chk_rd(8'h3c, 32'h0);
    base = {16'($urandom), 16'h0};
    ahb(1'b1, `TXQ_OFF_DESC_BASE, base);
    pkt(3'd0, 2, 0, 0, 32);
    hq.push_back({3'd0, sa(0)});
    pkt(3'd0, 1, 2, 0, 32);
    dq.push_back({sa(1), sa(2)});
    ahb(1'b1, `TXQ_OFF_CH_SEL, 32'h5);
    ahb(1'b1, `TXQ_OFF_CH_CFG, 32'h0000_02a0);
    ahb(1'b1, `TXQ_OFF_FRAG_PUSH, 32'h4000_0000);
    chk_rd(`TXQ_OFF_ERROR, 32'h1);
    ahb(1'b1, `TXQ_OFF_ERROR, 32'h7);
    ahb(1'b1, `TXQ_OFF_FRAG_PUSH, 32'h8000_0000);
    ahb(1'b1, `TXQ_OFF_FRAG_PUSH, 32'h8000_0000);
    chk_rd(`TXQ_OFF_ERROR, 32'h2);
    ahb(1'b1, `TXQ_OFF_ERROR, 32'h7);
    ahb(1'b1, `TXQ_OFF_FRAG_PUSH, 32'h8000_0000);
    ahb(1'b1, `TXQ_OFF_CHAIN_ABORT, 32'h1);
    chk_rd(`TXQ_OFF_ERROR, 32'h2);
    ahb(1'b1, `TXQ_OFF_ERROR, 32'h7);
    ahb(1'b1, `TXQ_OFF_PKT_INFO, 32'h5);
    ahb(1'b1, `TXQ_OFF_FRAG_PUSH, 32'h8000_0000);
    ahb(1'b1, `TXQ_OFF_FRAG_PUSH, 32'h0);
    ahb(1'b1, `TXQ_OFF_FRAG_PUSH, 32'h4000_0000);
    chk_rd(`TXQ_OFF_ERROR, 32'h1);
    ahb(1'b1, `TXQ_OFF_ERROR, 32'h7);
    chk_rd(`TXQ_OFF_ERROR, 32'h0);
    drain();
    pkt(3'd5, 2, 160, 160, 2);
    hq.push_back({3'd5, sa(160)});
    drain();
    chk_rd(`TXQ_OFF_CH_STAT, 32'ha0a0_0002);
    pkt(3'd5, 1, 160, 160, 2);
    dq.push_back({sa(161), sa(160)});
    pkt(3'd3, 1, 96, 96, 32);
    hq.push_back({3'd3, sa(96)});
    repeat (60) @(posedge hclk);
    `CHK(dq.size(), 9)
    ahb(1'b0, `TXQ_OFF_STATUS, 32'h0);
    `CHK(rd[31:1], 31'h0001_0100)
    ahb(1'b1, `TXQ_OFF_RELEASE, 32'h0000_0105);
    drain();
    hq.push_back({3'd5, sa(161)});
    ahb(1'b1, `TXQ_OFF_RESTART, 32'h5);
    drain();
    `CHK(i_txq_dev_model.frames, 5)
    finish_test();
  end
endmodule
`default_nettype wire
